// [verilog/dlrl_top.sv]
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "dlrl_params.svh"

// Dual liquid level relay logic with an AHB-Lite control slave
module dlrl_top import dlrl_pkg::*; #(
  parameter int unsigned TICK_CYC = `DLRL_TICK_CYC,
  parameter logic [31:0] CTRL_RESET = `DLRL_CTRL_RESET
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic low_level_cutoff_probe,
  input wire logic upper_probe,
  input wire logic lower_probe,
  input wire logic reset_loop_closed,
  output logic cutoff_relay,
  output logic cutoff_relay_indicator_lamp,
  output logic diff_relay,
  output logic diff_relay_indicator_lamp,
  output logic [1:0] sens_sel
);

  localparam int TW = `DLRL_TMR_W;
  localparam int DW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] RISE_STD_T =
    TW'(`DLRL_RISE_STD_MS / `DLRL_TICK_MS);
  localparam logic [TW-1:0] CUT_STD_T =
    TW'(`DLRL_CUT_STD_MS / `DLRL_TICK_MS);
  localparam logic [TW-1:0] CUT_LONG_T =
    TW'(`DLRL_CUT_LONG_MS / `DLRL_TICK_MS);
  localparam logic [TW-1:0] SEC_T =
    TW'(`DLRL_SEC_MS / `DLRL_TICK_MS);

  // Whole seconds to ticks, clamped to the supported range
  function automatic logic [TW-1:0] sec_ticks(input logic [4:0] s);
    logic [4:0] c;
    c = (s > `DLRL_DLY_MAX_S) ? `DLRL_DLY_MAX_S : s;
    return TW'(c * SEC_T);
  endfunction

  // Tick divider: one-cycle enable every tick period
  logic [DW-1:0] div_r;
  logic tick_r;
  logic div_end;
  assign div_end = (div_r == DW'(TICK_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_end ? '0 : div_r + 1'b1;
      tick_r <= div_end;
    end
  end

  // Two-stage synchronisers; stage one feeds only stage two
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      // Loop bit starts closed, so reset never looks like a press
      sync1_r <= 4'h8;
      sync2_r <= 4'h8;
    end else begin
      sync1_r <= {reset_loop_closed, lower_probe, upper_probe,
                  low_level_cutoff_probe};
      sync2_r <= sync1_r;
    end
  end

  logic cut_wet;
  logic up_wet;
  logic low_wet_raw;
  logic loop_closed;
  logic press;
  assign cut_wet = sync2_r[0];
  assign up_wet = sync2_r[1];
  assign low_wet_raw = sync2_r[2];
  assign loop_closed = sync2_r[3];
  // A press opens the normally closed loop
  assign press = !loop_closed;

  // Control register and its fields
  logic [31:0] ctrl_r;
  logic cfg_inv;
  logic cfg_cut6;
  logic cfg_man;
  logic cfg_po;
  logic cfg_single;
  logic [4:0] cfg_rise_s;
  logic [4:0] cfg_fall_s;
  assign cfg_inv = ctrl_r[`DLRL_C_INV];
  assign cfg_cut6 = ctrl_r[`DLRL_C_CUT6];
  assign cfg_man = ctrl_r[`DLRL_C_MAN];
  assign cfg_po = ctrl_r[`DLRL_C_PO];
  assign cfg_single = ctrl_r[`DLRL_C_SINGLE];
  assign cfg_rise_s = ctrl_r[`DLRL_C_RISE_HI:`DLRL_C_RISE_LO];
  assign cfg_fall_s = ctrl_r[`DLRL_C_FALL_HI:`DLRL_C_FALL_LO];

  // Cutoff dry timer: three or six seconds
  logic [TW-1:0] cut_lim;
  logic cut_dry_done;
  assign cut_lim = cfg_cut6 ? CUT_LONG_T : CUT_STD_T;

  dlrl_delay_timer #(.W(TW)) u_cut_dry (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick_r),
    .cond(!cut_wet),
    .limit(cut_lim),
    .done(cut_dry_done)
  );

  // Level seen: set at once when wet, dropped only after the dry delay
  logic cut_level_r;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cut_level_r <= 1'b0;
    end else if (cut_wet) begin
      cut_level_r <= 1'b1;
    end else if (cut_dry_done) begin
      cut_level_r <= 1'b0;
    end
  end

  // Outage arm: set by power-up, spent by any confirmed loss of liquid
  logic armed_r;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      armed_r <= 1'b1;
    end else if (cut_dry_done) begin
      armed_r <= 1'b0;
    end
  end

  // Cutoff channel state machine
  dlrl_cut_t cut_r;
  dlrl_cut_t cut_nxt;
  logic cut_go;
  // Without manual reset the relay simply follows the level
  assign cut_go = !cfg_man || press || (cfg_po && armed_r);

  always_comb begin
    cut_nxt = cut_r;
    unique case (cut_r)
      DLRL_CUT_DRY: begin
        if (cut_level_r) begin
          cut_nxt = cut_go ? DLRL_CUT_ON : DLRL_CUT_WAIT;
        end
      end
      DLRL_CUT_WAIT: begin
        if (!cut_level_r) begin
          cut_nxt = DLRL_CUT_DRY;
        end else if (cut_go) begin
          cut_nxt = DLRL_CUT_ON;
        end
      end
      DLRL_CUT_ON: begin
        if (!cut_level_r) begin
          cut_nxt = DLRL_CUT_DRY;
        end
      end
      default: cut_nxt = DLRL_CUT_DRY;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cut_r <= DLRL_CUT_DRY;
    end else begin
      cut_r <= cut_nxt;
    end
  end

  // Differential channel: single-level service reuses the upper probe
  logic low_wet;
  logic [TW-1:0] rise_lim;
  logic [TW-1:0] fall_lim;
  logic rise_done;
  logic fall_done;
  assign low_wet = cfg_single ? up_wet : low_wet_raw;
  assign rise_lim = (cfg_rise_s == 5'h00) ? RISE_STD_T :
                    sec_ticks(cfg_rise_s);
  // No falling delay unless one is configured
  assign fall_lim = (cfg_fall_s == 5'h00) ? '0 :
                    sec_ticks(cfg_fall_s);

  dlrl_delay_timer #(.W(TW)) u_rise (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick_r),
    .cond(up_wet),
    .limit(rise_lim),
    .done(rise_done)
  );

  dlrl_delay_timer #(.W(TW)) u_fall (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick_r),
    .cond(!low_wet),
    .limit(fall_lim),
    .done(fall_done)
  );

  // High latch; a wet upper probe wins over a dry lower probe
  logic diff_hi_r;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      diff_hi_r <= 1'b0;
    end else if (rise_done) begin
      diff_hi_r <= 1'b1;
    end else if (fall_done) begin
      diff_hi_r <= 1'b0;
    end
  end

  // Relay and lamp drivers, each channel on its own flops
  logic cut_on_nxt;
  logic diff_on_nxt;
  assign cut_on_nxt = (cut_nxt == DLRL_CUT_ON);
  // Inverse mode energizes from reset because the latch starts low
  assign diff_on_nxt = cfg_inv ? !diff_hi_r : diff_hi_r;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cutoff_relay <= 1'b0;
      cutoff_relay_indicator_lamp <= 1'b0;
      diff_relay <= 1'b0;
      diff_relay_indicator_lamp <= 1'b0;
      sens_sel <= 2'h0;
    end else begin
      cutoff_relay <= cut_on_nxt;
      cutoff_relay_indicator_lamp <= cut_on_nxt;
      diff_relay <= diff_on_nxt;
      diff_relay_indicator_lamp <= diff_on_nxt;
      sens_sel <= ctrl_r[`DLRL_C_SENS_HI:`DLRL_C_SENS_LO];
    end
  end

  // Status word shows live channel state
  logic [31:0] stat_w;
  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[`DLRL_S_RCUT] = cutoff_relay;
    stat_w[`DLRL_S_RDIF] = diff_relay;
    stat_w[`DLRL_S_CWET] = cut_wet;
    stat_w[`DLRL_S_UWET] = up_wet;
    stat_w[`DLRL_S_LWET] = low_wet_raw;
    stat_w[`DLRL_S_PRESS] = press;
    stat_w[`DLRL_S_CLVL] = cut_level_r;
    stat_w[`DLRL_S_ARMED] = armed_r;
    stat_w[`DLRL_S_DHI] = diff_hi_r;
    stat_w[`DLRL_S_WAIT] = (cut_r == DLRL_CUT_WAIT);
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic take;
  logic wr_pend_r;
  logic [`DLRL_ADDR_W-1:0] wr_addr_r;
  logic [`DLRL_ADDR_W-1:0] a_lo;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] rd_mux;
  assign take = hsel && htrans[1] && hready;
  assign a_lo = haddr[`DLRL_ADDR_W-1:0];
  // Decode full address so aliases read as unmapped
  assign hit_ctrl = (haddr[31:`DLRL_ADDR_W] == '0) &&
                    (a_lo == `DLRL_CTRL_OFS);
  assign hit_stat = (haddr[31:`DLRL_ADDR_W] == '0) &&
                    (a_lo == `DLRL_STAT_OFS);
  assign rd_mux = hit_ctrl ? ctrl_r : hit_stat ? stat_w : 32'h0000_0000;

  // Address phase capture and read data launch
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite && hit_ctrl;
      wr_addr_r <= a_lo;
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Data phase write; only the control word is writable
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_pend_r && (wr_addr_r == `DLRL_CTRL_OFS)) begin
      ctrl_r <= hwdata;
    end
  end

endmodule

// [verilog/dlrl_params.svh]
`ifndef DLRL_PARAMS_SVH
`define DLRL_PARAMS_SVH

// Clock and timer tick
`define DLRL_CLK_NS 10
`define DLRL_TICK_NS 10000000
`define DLRL_TICK_CYC (`DLRL_TICK_NS / `DLRL_CLK_NS)
`define DLRL_TMR_W 12

// Delays in milliseconds, converted to 10 ms ticks
`define DLRL_TICK_MS 10
`define DLRL_SEC_MS 1000
`define DLRL_RISE_STD_MS 500
`define DLRL_CUT_STD_MS 3000
`define DLRL_CUT_LONG_MS 6000
`define DLRL_DLY_MAX_S 5'h14

// Register byte offsets
`define DLRL_ADDR_W 8
`define DLRL_CTRL_OFS 8'h00
`define DLRL_STAT_OFS 8'h04

// Control register fields
`define DLRL_C_INV 0
`define DLRL_C_CUT6 1
`define DLRL_C_MAN 2
`define DLRL_C_PO 3
`define DLRL_C_SINGLE 4
`define DLRL_C_SENS_LO 8
`define DLRL_C_SENS_HI 9
`define DLRL_C_RISE_LO 16
`define DLRL_C_RISE_HI 20
`define DLRL_C_FALL_LO 24
`define DLRL_C_FALL_HI 28
`define DLRL_CTRL_RESET 32'h0000_0000

// Status register fields
`define DLRL_S_RCUT 0
`define DLRL_S_RDIF 1
`define DLRL_S_CWET 2
`define DLRL_S_UWET 3
`define DLRL_S_LWET 4
`define DLRL_S_PRESS 5
`define DLRL_S_CLVL 6
`define DLRL_S_ARMED 7
`define DLRL_S_DHI 8
`define DLRL_S_WAIT 9

`endif

// [verilog/dlrl_pkg.sv]
package dlrl_pkg;

  // Cutoff channel: dry, wet awaiting pushbutton, energized
  typedef enum logic [1:0] {
    DLRL_CUT_DRY,
    DLRL_CUT_WAIT,
    DLRL_CUT_ON
  } dlrl_cut_t;

  // Sensitivity codes passed to the probe front end
  typedef enum logic [1:0] {
    DLRL_SENS_4K7,
    DLRL_SENS_10K,
    DLRL_SENS_26K,
    DLRL_SENS_RSVD
  } dlrl_sens_t;

endpackage

// [verilog/dlrl_delay_timer.sv]
`timescale 1ns/1ps
`include "dlrl_params.svh"

// Counts ticks while a condition holds; restarts whenever it drops
module dlrl_delay_timer import dlrl_pkg::*; #(
  parameter int W = `DLRL_TMR_W
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  output logic done
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic done_nxt;
  logic reached;

  // Limit of zero means act on the first cycle the condition holds
  assign reached = (cnt_r >= limit);
  assign done_nxt = cond && reached;
  assign cnt_nxt = !cond ? '0 :
                   (tick && !reached) ? cnt_r + 1'b1 : cnt_r;

  // Counter and result flop
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_r <= '0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done <= done_nxt;
    end
  end

endmodule

// [sim/dlrl_props.sv]
`timescale 1ns/1ps
// Port-level checks of the relay logic and its control slave
module dlrl_props import dlrl_pkg::*; #(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic low_level_cutoff_probe,
  input wire logic cutoff_relay,
  input wire logic cutoff_relay_indicator_lamp,
  input wire logic diff_relay,
  input wire logic diff_relay_indicator_lamp,
  input wire logic [1:0] sens_sel
);
  localparam int DRY_MIN = 299 * TICK_CYC;
  localparam int DRY_MAX = 601 * TICK_CYC + 10;
  int dry_c = 0;
  int wet_c = 0;
  wire take = hsel && htrans[1] && hready;
  // One edge of grace after release so past values are never from reset
  logic live_r = 1'b0;
  always_ff @(posedge ref_clk) begin
    live_r <= nrst;
  end

  // Raw run lengths; the tick phase costs up to one tick of slack
  always_ff @(posedge ref_clk) begin
    dry_c <= low_level_cutoff_probe ? 0 : dry_c + 1;
    wet_c <= low_level_cutoff_probe ? wet_c + 1 : 0;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst || !live_r);

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  AST_CUT_LAMP: assert property (
    cutoff_relay_indicator_lamp == cutoff_relay)
    else $error("cutoff lamp differs from relay");
  AST_DIF_LAMP: assert property (
    diff_relay_indicator_lamp == diff_relay)
    else $error("diff lamp differs from relay");
  AST_CUT_DRY: assert property (
    $fell(cutoff_relay) |-> dry_c >= DRY_MIN)
    else $error("cutoff dropped too early");
  AST_CUT_WET: assert property (
    $rose(cutoff_relay) |-> wet_c >= 3)
    else $error("cutoff rose without wet probe");
  AST_CUT_DRYOFF: assert property (
    dry_c > DRY_MAX |-> !cutoff_relay)
    else $error("cutoff held after dry delay");
  AST_SENS_WR: assert property (
    take && hwrite && haddr == 32'h0 |=> ##2
    sens_sel == $past(hwdata[9:8], 2))
    else $error("sensitivity not taken from write");
  AST_RD_HOLE: assert property (
    take && !hwrite && haddr != 32'h0 && haddr != 32'h4
    |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind dlrl_top dlrl_props #(.TICK_CYC(TICK_CYC)) u_props (.ref_clk,
  .nrst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .low_level_cutoff_probe, .cutoff_relay,
  .cutoff_relay_indicator_lamp, .diff_relay, .diff_relay_indicator_lamp,
  .sens_sel);

// [sim/dlrl_plant.sv]
`timescale 1ns/1ps
// Tank with stacked probes and the reset pushbutton loop
module dlrl_plant (
  input wire logic [1:0] level,
  input wire logic press,
  input wire logic jumper,
  output logic cut_wet,
  output logic up_wet,
  output logic lo_wet,
  output logic loop_ok
);
  // Cutoff probe lowest, long probe next, short probe on top
  assign cut_wet = level >= 2'h1;
  assign up_wet = level == 2'h3;
  assign lo_wet = jumper ? up_wet : level >= 2'h2;
  // Normally closed button: a press opens the loop
  assign loop_ok = !press;
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
// Self-checking bench for the relay logic
module testbench import dlrl_pkg::*;;
  logic ref_clk = 0;
  logic nrst = 0;
  logic hsel = 1;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0;
  logic [1:0] level = 2'h1;
  logic press = 0;
  logic jumper = 0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cutoff_relay, cutoff_relay_indicator_lamp;
  logic diff_relay, diff_relay_indicator_lamp;
  logic [1:0] sens_sel;
  logic low_level_cutoff_probe, upper_probe, lower_probe;
  logic reset_loop_closed;
  wire hready = hreadyout;
  int error_cnt = 0;
  int n_checks = 0;

  // Ten cycle tick keeps the second-long delays short
  dlrl_top #(.TICK_CYC(10), .CTRL_RESET(32'h0000_000c)) DUT (.ref_clk,
    .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .low_level_cutoff_probe, .upper_probe,
    .lower_probe, .reset_loop_closed, .cutoff_relay,
    .cutoff_relay_indicator_lamp, .diff_relay, .diff_relay_indicator_lamp,
    .sens_sel);
  dlrl_plant u_plant (.level, .press, .jumper,
    .cut_wet(low_level_cutoff_probe), .up_wet(upper_probe),
    .lo_wet(lower_probe), .loop_ok(reset_loop_closed));

  initial forever #5 ref_clk = ~ref_clk;

  task chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Single word transfer; the wait has no fixed count, the watchdog cuts it
  task bus(input logic w, input logic [31:0] a, d,
           output logic [31:0] rd);
    @(posedge ref_clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task wr(input logic [31:0] a, d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rdc(input logic [31:0] a, e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e, "read data");
  endtask

  task lv(input logic [1:0] v);
    @(posedge ref_clk);
    level <= v;
  endtask

  // Relay is old at one sample after q cycles, then flips within w (w 0: only that sample)
  task span(input bit d, input logic old, input int q, w);
    logic [31:0] s;
    // Never sample in the time step of the edge that launches the relay
    @(negedge ref_clk);
    repeat (q) @(negedge ref_clk);
    s = {31'h0, d ? diff_relay : cutoff_relay};
    chk(s, {31'h0, old}, "relay moved early");
    for (int i = 0; i < w && s[0] === old; i++) begin
      @(negedge ref_clk);
      s = {31'h0, d ? diff_relay : cutoff_relay};
    end
    if (w > 0) chk(s, {31'h0, !old}, "relay late");
  endtask

  task t_outage;
    span(0, 0, 0, 8);
    rdc(32'h0, 32'h0000_000c);
    lv(2'h0);
    span(0, 1, 2980, 40);
    lv(2'h1);
    span(0, 0, 200, 0);
    @(posedge ref_clk);
    press <= 1'b1;
    span(0, 0, 0, 8);
    @(posedge ref_clk);
    press <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    span(0, 0, 0, 8);
  endtask

  task t_regs;
    for (int i = 0; i < 3; i++) begin
      wr(32'h0, 32'(i) << 8);
      repeat (3) @(negedge ref_clk);
      chk(32'(sens_sel), 32'(i), "sensitivity");
      rdc(32'h0, 32'(i) << 8);
    end
    rdc(32'h8, 32'h0);
    rdc(32'h4, 32'h0000_00c5);
  endtask

  task t_cutoff;
    lv(2'h0);
    repeat (1500) @(negedge ref_clk);
    lv(2'h1);
    lv(2'h0);
    span(0, 1, 2980, 40);
    wr(32'h0, 32'h2);
    lv(2'h1);
    span(0, 0, 0, 8);
    lv(2'h0);
    span(0, 1, 5980, 40);
    lv(2'h1);
    span(0, 0, 0, 8);
  endtask

  task t_diff(input logic [31:0] c, input int r, f);
    wr(32'h0, c);
    lv(2'h3);
    span(1, 0, r, 40);
    lv(2'h2);
    span(1, 1, 1000, 0);
    lv(2'h1);
    span(1, 1, f, 40);
  endtask

  task t_modes;
    wr(32'h0, 32'h10);
    jumper <= 1'b1;
    lv(2'h3);
    span(1, 0, 480, 40);
    lv(2'h2);
    span(1, 1, 0, 40);
    lv(2'h1);
    jumper <= 1'b0;
    wr(32'h0, 32'h1);
    span(1, 0, 0, 8);
    lv(2'h3);
    span(1, 1, 480, 40);
    lv(2'h1);
    span(1, 0, 0, 40);
    chk({31'h0, cutoff_relay}, 32'h1, "cutoff disturbed");
  endtask

  task final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_outage();
    t_regs();
    t_cutoff();
    t_diff(32'h0, 480, 0);
    t_diff(32'h0201_0000, 980, 1980);
    t_modes();
    final_report();
  end

  // Run needs about 20400 cycles; half a millisecond is ample
  initial begin
    #500us;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
